// ==== rtl/bkpt_top.sv ====
// Hardware breakpoint compare and instruction tagging, with APB registers.
// Assumes CPU bus signals, bus clock and tag pins are synchronous to CLOCK.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "bkpt_regs.svh"

module bkpt_top (
    input  wire logic        CLOCK,          // System clock, 20 MHz
    input  wire logic        RSTN,           // Asynchronous reset, low active
    input  wire logic        CE,             // Clock enable, freezes all state
    input  wire logic        PSEL,           // APB select
    input  wire logic        PENABLE,        // APB access phase
    input  wire logic        PWRITE,         // APB direction
    input  wire logic [11:0] PADDR,          // APB byte address
    input  wire logic [31:0] PWDATA,         // APB write data
    output logic      [31:0] PRDATA,         // APB read data
    output logic             PREADY,         // APB ready
    output logic             PSLVERR,        // APB error on unmapped address
    output logic             IRQ,            // Level interrupt
    input  wire logic [15:0] CPU_ADDR,       // CPU address bus
    input  wire logic [15:0] CPU_DATA,       // CPU data bus
    input  wire logic        CPU_READ,       // High for read cycle
    input  wire logic        CPU_CYCLE,      // Valid bus cycle strobe
    input  wire logic        PROG_FETCH,     // Program word fetched this bus cycle
    input  wire logic        QUEUE_ADVANCE,  // Queue head byte consumed
    input  wire logic        DEBUG_HALT,     // Debug halt state active
    input  wire logic        BUS_CLOCK,      // Bus clock level
    input  wire logic        DBG_PIN_IN,     // Single wire debug pin level
    input  wire logic        DBG_PIN_OUT_IN, // Debug unit drive value
    input  wire logic        DBG_PIN_OE_IN,  // Debug unit drive enable
    output logic             DBG_PIN_OUT,    // Debug pin drive value
    output logic             DBG_PIN_OE,     // Debug pin drive enable
    input  wire logic        LO_PIN_IN,      // Port E bit 3 pin level
    input  wire logic        LO_PORT_OUT,    // Port logic drive value
    input  wire logic        LO_PORT_OE,     // Port logic drive enable
    input  wire logic        STROBE_IN,      // Low byte strobe from bus logic
    output logic             LO_PIN_OUT,     // Port E bit 3 drive value
    output logic             LO_PIN_OE,      // Port E bit 3 drive enable
    output logic             TAGGING,        // Tagging active
    output logic             SERIAL_CMD_EN,  // Debug serial commands allowed
    output logic             BREAK_SWI,      // Software interrupt request pulse
    output logic             BREAK_DEBUG,    // Debug halt request pulse
    output logic             TAG_HALT        // Tagged instruction at queue head
);
    import bkpt_pkg::*;

    bkpt_state_type s_q;
    bkpt_state_type s_d;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Register index from a byte address, 6'h3F when unaligned
    function automatic logic [5:0] reg_index(input logic [11:0] a);
        reg_index = (a[1:0] == 2'b00 && a[11:8] == 4'h0) ? a[7:2] : 6'h3F;
    endfunction

    // Direction qualifier: passes when disabled
    function automatic logic dir_ok(input logic en, input logic val, input logic rd);
        dir_ok = !en || (val == rd);
    endfunction

    // Byte compare, skipped when not used
    function automatic logic byte_ok(input logic use_it, input logic [7:0] r,
                                     input logic [7:0] b);
        byte_ok = !use_it || (r == b);
    endfunction

    // ------------------------------------------------------------
    // Breakpoint compare
    // ------------------------------------------------------------

    bkpt_mode_type mode;
    logic          data_en;
    logic          addr0_hit;
    logic          dir0_hit;
    logic          dir1_hit;
    logic          data_hit;
    logic          dual_hit;
    logic          bp0_hit;
    logic          bp1_hit;
    logic          brk_allowed;

    // Compare terms; masks only matter in full mode
    always_comb begin
        mode     = bkpt_mode_type'(s_q.ctrl0[`BKPT_C0_MODE_HI:`BKPT_C0_MODE_LO]);
        data_en  = s_q.ctrl1[`BKPT_C1_DATA_EN];
        addr0_hit = (s_q.addr_hi == CPU_ADDR[15:8])
            && byte_ok(s_q.ctrl0[`BKPT_C0_BP0_RANGE], s_q.addr_lo, CPU_ADDR[7:0]);
        dir0_hit = dir_ok(s_q.ctrl1[`BKPT_C1_BP0_DIR_EN],
                          s_q.ctrl1[`BKPT_C1_BP0_DIR_VAL], CPU_READ);
        dir1_hit = dir_ok(s_q.ctrl1[`BKPT_C1_BP1_DIR_EN],
                          s_q.ctrl1[`BKPT_C1_BP1_DIR_VAL], CPU_READ);
        data_hit = !data_en
            || (byte_ok(!s_q.ctrl1[`BKPT_C1_MASK_HIGH], s_q.data_hi, CPU_DATA[15:8])
            && byte_ok(!s_q.ctrl1[`BKPT_C1_MASK_LOW], s_q.data_lo, CPU_DATA[7:0]));
        dual_hit = data_en && (s_q.data_hi == CPU_ADDR[15:8])
            && byte_ok(s_q.ctrl0[`BKPT_C0_BP1_RANGE], s_q.data_lo, CPU_ADDR[7:0]);
        brk_allowed = CPU_CYCLE && !DEBUG_HALT;
        bp0_hit = 1'b0;
        bp1_hit = 1'b0;
        unique case (mode)
            BKPT_MODE_OFF: begin
                bp0_hit = 1'b0;
            end
            BKPT_MODE_SWI_DUAL: begin
                // Direction bits have no say in the software interrupt mode
                bp0_hit = brk_allowed && addr0_hit;
                bp1_hit = brk_allowed && dual_hit;
            end
            BKPT_MODE_FULL: begin
                bp0_hit = brk_allowed && addr0_hit && dir0_hit && data_hit;
            end
            BKPT_MODE_DBG_DUAL: begin
                bp0_hit = brk_allowed && addr0_hit && dir0_hit;
                bp1_hit = brk_allowed && dual_hit && dir1_hit;
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    logic [5:0] idx;
    logic       mapped;
    logic       wr_en;
    logic       setup;
    logic [7:0] rd_byte;

    // Zero wait states; read data is captured in the setup cycle
    always_comb begin
        idx    = reg_index(PADDR);
        mapped = (idx >= `BKPT_IDX_CTRL0) && (idx <= `BKPT_IDX_DEBUG_CTRL);
        setup  = PSEL && !PENABLE;
        wr_en  = PSEL && PENABLE && PWRITE && mapped;
        unique case (idx)
            `BKPT_IDX_CTRL0:      rd_byte = s_q.ctrl0;
            `BKPT_IDX_CTRL1:      rd_byte = s_q.ctrl1;
            `BKPT_IDX_ADDR_HIGH:  rd_byte = s_q.addr_hi;
            `BKPT_IDX_ADDR_LOW:   rd_byte = s_q.addr_lo;
            `BKPT_IDX_DATA_HIGH:  rd_byte = s_q.data_hi;
            `BKPT_IDX_DATA_LOW:   rd_byte = s_q.data_lo;
            `BKPT_IDX_IRQ_STATUS: rd_byte = {5'h00, s_q.irq_status};
            `BKPT_IDX_IRQ_MASK:   rd_byte = {5'h00, s_q.irq_mask};
            `BKPT_IDX_DEBUG_CTRL: rd_byte = {7'h00, s_q.tag_state == TAG_ACTIVE};
            default:              rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    logic       bclk_fall;
    logic       halt_rise;
    logic       tag_cmd;
    logic       tag_on;
    logic [2:0] cnt_a;
    logic [5:0] tag_a;

    always_comb begin
        s_d       = s_q;
        tag_on    = (s_q.tag_state == TAG_ACTIVE);
        bclk_fall = s_q.bclk_prev && !BUS_CLOCK;
        halt_rise = DEBUG_HALT && !s_q.halt_prev;
        tag_cmd   = wr_en && (idx == `BKPT_IDX_DEBUG_CTRL) && PWDATA[`BKPT_DC_TAG_CMD];
        cnt_a     = s_q.q_cnt;
        tag_a     = s_q.q_tag;

        s_d.halt_prev = DEBUG_HALT;
        s_d.bclk_prev = BUS_CLOCK;
        if (setup) begin
            s_d.prdata = {24'h00_0000, rd_byte};
        end

        // Register writes
        if (wr_en) begin
            unique case (idx)
                `BKPT_IDX_CTRL0:     s_d.ctrl0   = PWDATA[7:0] & `BKPT_C0_RW_MASK;
                `BKPT_IDX_CTRL1:     s_d.ctrl1   = PWDATA[7:0] & `BKPT_C1_RW_MASK;
                `BKPT_IDX_ADDR_HIGH: s_d.addr_hi = PWDATA[7:0];
                `BKPT_IDX_ADDR_LOW:  s_d.addr_lo = PWDATA[7:0];
                `BKPT_IDX_DATA_HIGH: s_d.data_hi = PWDATA[7:0];
                `BKPT_IDX_DATA_LOW:  s_d.data_lo = PWDATA[7:0];
                `BKPT_IDX_IRQ_MASK:  s_d.irq_mask = PWDATA[2:0];
                `BKPT_IDX_IRQ_STATUS: s_d.irq_status = s_q.irq_status & ~PWDATA[2:0];
                default: s_d.ctrl0 = s_q.ctrl0;
            endcase
        end

        // Tagging state; halt entry beats a command in the same cycle
        unique case (s_q.tag_state)
            TAG_IDLE: begin
                if (tag_cmd && !halt_rise) begin
                    s_d.tag_state = TAG_ACTIVE;
                end
            end
            TAG_ACTIVE: begin
                if (DEBUG_HALT) begin
                    s_d.tag_state = TAG_IDLE;
                end
            end
        endcase

        // Bus clock phase lengths, used to place the strobe window
        if (BUS_CLOCK != s_q.bclk_prev) begin
            if (BUS_CLOCK) begin
                s_d.low_len = s_q.phase_cnt;
            end else begin
                s_d.high_len = s_q.phase_cnt;
            end
            s_d.phase_cnt = 8'h01;
        end else if (s_q.phase_cnt != 8'hFF) begin
            s_d.phase_cnt = s_q.phase_cnt + 8'h01;
        end

        // Queue: head pops first, then a fetched word enters high byte first
        if (QUEUE_ADVANCE && cnt_a != 3'd0) begin
            tag_a = {1'b0, tag_a[5:1]};
            cnt_a = cnt_a - 3'd1;
        end
        if (bclk_fall && PROG_FETCH && cnt_a <= `BKPT_QUEUE_FULL2) begin
            tag_a[cnt_a]         = tag_on && !DBG_PIN_IN;
            tag_a[cnt_a + 3'd1]  = tag_on && !LO_PIN_IN;
            cnt_a = cnt_a + 3'd2;
        end
        if (halt_rise) begin
            // Halt discards prefetched bytes, so stale tags cannot fire later
            cnt_a = 3'd0;
            tag_a = 6'h00;
        end
        s_d.q_cnt = cnt_a;
        s_d.q_tag = tag_a;

        // Break outputs and sticky events; a new event wins over a clear
        s_d.tag_halt = (s_q.q_cnt != 3'd0) && s_q.q_tag[0] && !DEBUG_HALT;
        s_d.brk_swi  = (mode == BKPT_MODE_SWI_DUAL) && (bp0_hit || bp1_hit);
        s_d.brk_dbg  = (mode == BKPT_MODE_FULL || mode == BKPT_MODE_DBG_DUAL)
                       && (bp0_hit || bp1_hit);
        s_d.irq_status[`BKPT_IRQ_BP0] = s_d.irq_status[`BKPT_IRQ_BP0] | bp0_hit;
        s_d.irq_status[`BKPT_IRQ_BP1] = s_d.irq_status[`BKPT_IRQ_BP1] | bp1_hit;
        s_d.irq_status[`BKPT_IRQ_TAG] = s_d.irq_status[`BKPT_IRQ_TAG]
                                        | (s_d.tag_halt && !s_q.tag_halt);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Whole state frozen while CE is low
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            s_q            <= '0;
            s_q.ctrl0      <= `BKPT_RST_BYTE;
            s_q.ctrl1      <= `BKPT_RST_BYTE;
            s_q.addr_hi    <= `BKPT_RST_BYTE;
            s_q.addr_lo    <= `BKPT_RST_BYTE;
            s_q.data_hi    <= `BKPT_RST_BYTE;
            s_q.data_lo    <= `BKPT_RST_BYTE;
            s_q.irq_status <= `BKPT_RST_IRQ;
            s_q.irq_mask   <= `BKPT_RST_IRQ;
            s_q.tag_state  <= TAG_IDLE;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs and shared pins
    // ------------------------------------------------------------

    logic strobe_window;

    // Combinational level keeps pace with phase_cnt; assumes a steady bus clock
    always_comb begin
        strobe_window = s_q.bclk_prev ? (s_q.phase_cnt < (s_q.high_len >> 1))
                                      : (s_q.phase_cnt >= (s_q.low_len >> 1));
    end

    // Bus answers and pin muxing
    always_comb begin
        PRDATA        = s_q.prdata;
        PREADY        = 1'b1;
        PSLVERR       = PSEL && PENABLE && !mapped;
        IRQ           = |(s_q.irq_status & s_q.irq_mask);
        TAGGING       = tag_on;
        SERIAL_CMD_EN = !tag_on;
        DBG_PIN_OUT   = DBG_PIN_OUT_IN;
        DBG_PIN_OE    = DBG_PIN_OE_IN && !tag_on;
        LO_PIN_OUT    = tag_on ? STROBE_IN : LO_PORT_OUT;
        LO_PIN_OE     = tag_on ? strobe_window : LO_PORT_OE;
        BREAK_SWI     = s_q.brk_swi;
        BREAK_DEBUG   = s_q.brk_dbg;
        TAG_HALT      = s_q.tag_halt;
    end

endmodule

// ==== inc/bkpt_regs.svh ====
// Register indices, field positions and reset values of the breakpoint block.
// Assumes byte address = index * 4 on a 32-bit APB.
`ifndef BKPT_REGS_SVH
`define BKPT_REGS_SVH

`define BKPT_IDX_CTRL0      6'h20
`define BKPT_IDX_CTRL1      6'h21
`define BKPT_IDX_ADDR_HIGH  6'h22
`define BKPT_IDX_ADDR_LOW   6'h23
`define BKPT_IDX_DATA_HIGH  6'h24
`define BKPT_IDX_DATA_LOW   6'h25
`define BKPT_IDX_IRQ_STATUS 6'h26
`define BKPT_IDX_IRQ_MASK   6'h27
`define BKPT_IDX_DEBUG_CTRL 6'h28

`define BKPT_RST_BYTE       8'h00
`define BKPT_RST_IRQ        3'h0

// Control 0 fields
`define BKPT_C0_MODE_HI     7
`define BKPT_C0_MODE_LO     6
`define BKPT_C0_PROG        5
`define BKPT_C0_BP1_RANGE   3
`define BKPT_C0_BP0_RANGE   2
`define BKPT_C0_RW_MASK     8'hEC

// Control 1 fields
`define BKPT_C1_DATA_EN     6
`define BKPT_C1_MASK_HIGH   5
`define BKPT_C1_MASK_LOW    4
`define BKPT_C1_BP1_DIR_EN  3
`define BKPT_C1_BP1_DIR_VAL 2
`define BKPT_C1_BP0_DIR_EN  1
`define BKPT_C1_BP0_DIR_VAL 0
`define BKPT_C1_RW_MASK     8'h7F

// Interrupt status bits
`define BKPT_IRQ_BP0        0
`define BKPT_IRQ_BP1        1
`define BKPT_IRQ_TAG        2

// Debug control bits
`define BKPT_DC_TAG_CMD     0

// Instruction queue length in bytes
`define BKPT_QUEUE_BYTES    6
`define BKPT_QUEUE_FULL2    3'd4

`endif

// ==== inc/bkpt_pkg.sv ====
// Types shared by the breakpoint and tagging block.
// Assumes the register header is included by the design files.
package bkpt_pkg;

    typedef enum logic [1:0] {
        BKPT_MODE_OFF,
        BKPT_MODE_SWI_DUAL,
        BKPT_MODE_FULL,
        BKPT_MODE_DBG_DUAL
    } bkpt_mode_type;

    typedef enum logic {
        TAG_IDLE,
        TAG_ACTIVE
    } bkpt_tag_state_type;

    typedef struct packed {
        logic [7:0]         ctrl0;
        logic [7:0]         ctrl1;
        logic [7:0]         addr_hi;
        logic [7:0]         addr_lo;
        logic [7:0]         data_hi;
        logic [7:0]         data_lo;
        logic [2:0]         irq_status;
        logic [2:0]         irq_mask;
        bkpt_tag_state_type tag_state;
        logic [31:0]        prdata;
        logic               halt_prev;
        logic               bclk_prev;
        logic [7:0]         phase_cnt;
        logic [7:0]         low_len;
        logic [7:0]         high_len;
        logic [2:0]         q_cnt;
        logic [5:0]         q_tag;
        logic               brk_swi;
        logic               brk_dbg;
        logic               tag_halt;
    } bkpt_state_type;

endpackage

// ==== sim/bkpt_top_asserts.sv ====
// Port-level checker for the breakpoint and tagging block.
// Assumes one clock domain and is bound onto every bkpt_top instance.
`timescale 1ns/10ps
module bkpt_top_asserts (
    input wire logic        CLOCK,         // System clock
    input wire logic        RSTN,          // Async reset, low active
    input wire logic        CE,            // Clock enable
    input wire logic        PSEL,          // APB select
    input wire logic        PENABLE,       // APB access phase
    input wire logic        PWRITE,        // APB direction
    input wire logic [11:0] PADDR,         // APB byte address
    input wire logic [31:0] PWDATA,        // APB write data
    input wire logic        PSLVERR,       // APB error
    input wire logic        CPU_CYCLE,     // Bus cycle strobe
    input wire logic        DEBUG_HALT,    // Debug halt active
    input wire logic        DBG_PIN_OE_IN, // Debug unit drive enable
    input wire logic        DBG_PIN_OE,    // Debug pin drive enable
    input wire logic        BUS_CLOCK,     // Bus clock level
    input wire logic        STROBE_IN,     // Strobe from bus logic
    input wire logic        LO_PIN_OUT,    // Port pin drive value
    input wire logic        LO_PIN_OE,     // Port pin drive enable
    input wire logic        TAGGING,       // Tagging active
    input wire logic        SERIAL_CMD_EN, // Serial commands allowed
    input wire logic        BREAK_SWI,     // Interrupt request pulse
    input wire logic        BREAK_DEBUG,   // Halt request pulse
    input wire logic        TAG_HALT       // Tagged byte at head
);
    logic tag_cmd;

    // ------------------------------------------------------------
    // Helper terms
    // ------------------------------------------------------------
    // Write of the tag command, seen at the access phase
    assign tag_cmd = PSEL && PENABLE && PWRITE && PADDR == 12'h0A0 && PWDATA[0];

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    cmd_gate_a: assert property (SERIAL_CMD_EN == !TAGGING)
        else $error("serial commands not gated by tagging");
    dbg_pin_free_a: assert property (DBG_PIN_OE == (DBG_PIN_OE_IN && !TAGGING))
        else $error("debug pin driven while tagging");
    strobe_drive_a: assert property (TAGGING && LO_PIN_OE |-> LO_PIN_OUT == STROBE_IN)
        else $error("shared pin not carrying the strobe");
    strobe_gap_a: assert property (TAGGING && $fell(BUS_CLOCK) |-> !LO_PIN_OE)
        else $error("strobe driven at bus fall");
    tag_off_halt_a: assert property (TAGGING && DEBUG_HALT && CE |-> ##2 !TAGGING)
        else $error("tagging kept on in halt");
    tag_start_cmd_a: assert property ($rose(TAGGING) |-> $past(tag_cmd) || $past(tag_cmd, 2))
        else $error("tagging started without command");
    halt_quiet_a: assert property (DEBUG_HALT && CE |=> !BREAK_SWI && !BREAK_DEBUG)
        else $error("breakpoint raised in halt");
    break_cause_a: assert property ((BREAK_SWI || BREAK_DEBUG) && $past(CE) |->
        $past(CPU_CYCLE) && !$past(DEBUG_HALT) && !(BREAK_SWI && BREAK_DEBUG))
        else $error("breakpoint pulse without a bus cycle");
    head_flush_a: assert property ($rose(DEBUG_HALT) && CE |-> ##2 !TAG_HALT)
        else $error("tag halt kept after halt entry");
    unaligned_err_a: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
        else $error("unaligned access not refused");

    // Main scenarios reached
    cover property ($rose(TAGGING));
    cover property (BREAK_SWI);
    cover property (BREAK_DEBUG);
    cover property ($rose(TAG_HALT));
endmodule

bind bkpt_top bkpt_top_asserts bkpt_top_asserts_i (.*);

// ==== sim/bkpt_tagger.sv ====
// Model of the external tagger on the two shared pins.
// Assumes pull-ups on both pins; resolves each wire from all drivers.
`timescale 1ns/10ps
module bkpt_tagger (
    input  wire logic tag_hi_req,  // Mark high byte of next fetch
    input  wire logic tag_lo_req,  // Mark low byte of next fetch
    input  wire logic dev_lo_oe,   // Device drives port pin
    input  wire logic dev_lo_out,  // Device port pin value
    input  wire logic dev_dbg_oe,  // Device drives debug pin
    input  wire logic dev_dbg_out, // Device debug pin value
    output logic      lo_level,    // Resolved port pin level
    output logic      dbg_level    // Resolved debug pin level
);
    // Tagger pulls low only while the device lets go; no serial traffic at all
    assign lo_level = dev_lo_oe ? dev_lo_out : !tag_lo_req;
    // High byte tag on the debug pin, pull-up when released
    assign dbg_level = dev_dbg_oe ? dev_dbg_out : !tag_hi_req;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for bkpt_top with the tagger model on its pins.
// Assumes the register header and package are compiled first.
`timescale 1ns/10ps
`include "bkpt_regs.svh"
module tb_top;
    import bkpt_pkg::*;
    logic        CLOCK = 1'b0, RSTN = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
    logic        PWRITE = 1'b0, CPU_READ = 1'b0, CPU_CYCLE = 1'b0, PROG_FETCH = 1'b0;
    logic        QUEUE_ADVANCE = 1'b0, DEBUG_HALT = 1'b0, BUS_CLOCK = 1'b0;
    logic        DBG_PIN_OUT_IN = 1'b0, DBG_PIN_OE_IN = 1'b0, LO_PORT_OUT = 1'b0;
    logic        LO_PORT_OE = 1'b0, STROBE_IN = 1'b1, hi_req = 1'b0, lo_req = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
    logic [15:0] CPU_ADDR = 16'h0000, CPU_DATA = 16'h0000;
    logic [2:0]  bc_cnt = 3'h0;
    logic        PREADY, PSLVERR, IRQ, DBG_PIN_IN, DBG_PIN_OUT, DBG_PIN_OE, LO_PIN_IN;
    logic        LO_PIN_OUT, LO_PIN_OE, TAGGING, SERIAL_CMD_EN, BREAK_SWI, BREAK_DEBUG, TAG_HALT;
    int          errors = 0, tests_run = 0;

    bkpt_top bkpt_top_i (.*);
    bkpt_tagger bkpt_tagger_i (
        .tag_hi_req  (hi_req),
        .tag_lo_req  (lo_req),
        .dev_lo_oe   (LO_PIN_OE),
        .dev_lo_out  (LO_PIN_OUT),
        .dev_dbg_oe  (DBG_PIN_OE),
        .dev_dbg_out (DBG_PIN_OUT),
        .lo_level    (LO_PIN_IN),
        .dbg_level   (DBG_PIN_IN)
    );

    // ------------------------------------------------------------
    // Clocks: 20 MHz system clock, bus clock of eight system cycles
    // ------------------------------------------------------------
    always #25 CLOCK = !CLOCK;
    always @(posedge CLOCK) begin
        bc_cnt    <= bc_cnt + 3'h1;
        BUS_CLOCK <= bc_cnt[2];
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [11:0] ba(input logic [5:0] i);
        return {4'h0, i, 2'b00};
    endfunction
    task automatic results;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, waits on pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk(32'(e), 32'(eexp));
    endtask
    // One CPU bus cycle; exp is {software interrupt, halt request}
    task automatic brk(input logic [15:0] a, input logic [15:0] d, input logic rd,
                       input logic [1:0] exp);
        @(posedge CLOCK);
        CPU_ADDR  <= a;
        CPU_DATA  <= d;
        CPU_READ  <= rd;
        CPU_CYCLE <= 1'b1;
        @(posedge CLOCK);
        CPU_CYCLE <= 1'b0;
        @(negedge CLOCK);
        chk(32'({BREAK_SWI, BREAK_DEBUG}), 32'(exp));
    endtask
    // Program fetch latched at the falling bus clock edge, tags held across it
    task automatic fetch(input logic hi, input logic lo);
        do @(posedge CLOCK); while (BUS_CLOCK !== 1'b1);
        PROG_FETCH <= 1'b1;
        hi_req     <= hi;
        lo_req     <= lo;
        do @(posedge CLOCK); while (BUS_CLOCK !== 1'b0);
        PROG_FETCH <= 1'b0;
        hi_req     <= 1'b0;
        lo_req     <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] m [6];
        m = '{8'hEC, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        for (int i = 0; i < 6; i++) begin
            rdc(ba(`BKPT_IDX_CTRL0 + 6'(i)), 32'h0000_0000, 1'b0);
            wr(ba(`BKPT_IDX_CTRL0 + 6'(i)), 8'hFF);
            rdc(ba(`BKPT_IDX_CTRL0 + 6'(i)), 32'(m[i]), 1'b0);
            wr(ba(`BKPT_IDX_CTRL0 + 6'(i)), 8'h00);
        end
        rdc(12'h081, 32'h0000_0000, 1'b1);
    endtask
    task automatic t_full;
        wr(ba(`BKPT_IDX_ADDR_HIGH), 8'h12);
        wr(ba(`BKPT_IDX_ADDR_LOW), 8'h34);
        wr(ba(`BKPT_IDX_CTRL0), {BKPT_MODE_FULL, 6'h04});
        wr(ba(`BKPT_IDX_CTRL1), 8'h03);
        brk(16'h1234, 16'h0000, 1'b1, 2'b01);
        brk(16'h1234, 16'h0000, 1'b0, 2'b00);
        brk(16'h1235, 16'h0000, 1'b1, 2'b00);
        brk(16'h1334, 16'h0000, 1'b1, 2'b00);
        wr(ba(`BKPT_IDX_CTRL1), 8'h40);
        wr(ba(`BKPT_IDX_DATA_HIGH), 8'h56);
        wr(ba(`BKPT_IDX_DATA_LOW), 8'h78);
        brk(16'h1234, 16'h5678, 1'b0, 2'b01);
        brk(16'h1234, 16'h5679, 1'b0, 2'b00);
        brk(16'h1234, 16'h5778, 1'b0, 2'b00);
        wr(ba(`BKPT_IDX_CTRL1), 8'h50);
        brk(16'h1234, 16'h5679, 1'b1, 2'b01);
        wr(ba(`BKPT_IDX_CTRL1), 8'h60);
        brk(16'h1234, 16'h9978, 1'b1, 2'b01);
        wr(ba(`BKPT_IDX_CTRL1), 8'h00);
        wr(ba(`BKPT_IDX_CTRL0), {BKPT_MODE_FULL, 6'h00});
        brk(16'h12FF, 16'hFFFF, 1'b0, 2'b01);
        @(posedge CLOCK);
        DEBUG_HALT <= 1'b1;
        brk(16'h12FF, 16'h0000, 1'b0, 2'b00);
        @(posedge CLOCK);
        DEBUG_HALT <= 1'b0;
    endtask
    task automatic t_irq;
        rdc(ba(`BKPT_IDX_IRQ_STATUS), 32'h0000_0001, 1'b0);
        chk(32'(IRQ), 32'h0000_0000);
        wr(ba(`BKPT_IDX_IRQ_MASK), 8'h01);
        @(negedge CLOCK);
        chk(32'(IRQ), 32'h0000_0001);
        wr(ba(`BKPT_IDX_IRQ_STATUS), 8'h01);
        @(negedge CLOCK);
        chk(32'(IRQ), 32'h0000_0000);
    endtask
    task automatic t_dual;
        wr(ba(`BKPT_IDX_DATA_HIGH), 8'hA0);
        wr(ba(`BKPT_IDX_DATA_LOW), 8'h0B);
        wr(ba(`BKPT_IDX_CTRL1), 8'h4B);
        wr(ba(`BKPT_IDX_CTRL0), {BKPT_MODE_DBG_DUAL, 6'h08});
        brk(16'hA00B, 16'h0000, 1'b0, 2'b01);
        brk(16'hA00B, 16'h0000, 1'b1, 2'b00);
        brk(16'hA00C, 16'h0000, 1'b0, 2'b00);
        brk(16'h1200, 16'h0000, 1'b0, 2'b00);
        brk(16'h1200, 16'h0000, 1'b1, 2'b01);
        wr(ba(`BKPT_IDX_CTRL0), {BKPT_MODE_SWI_DUAL, 6'h08});
        brk(16'hA00B, 16'h0000, 1'b1, 2'b10);
        brk(16'h1200, 16'h0000, 1'b0, 2'b10);
        wr(ba(`BKPT_IDX_CTRL0), {BKPT_MODE_OFF, 6'h08});
        brk(16'hA00B, 16'h0000, 1'b0, 2'b00);
    endtask
    task automatic t_tag;
        wr(ba(`BKPT_IDX_IRQ_STATUS), 8'h07);
        DBG_PIN_OE_IN <= 1'b1;
        wr(ba(`BKPT_IDX_DEBUG_CTRL), 8'h01);
        repeat (2) @(negedge CLOCK);
        chk(32'({TAGGING, SERIAL_CMD_EN, DBG_PIN_OE}), 32'h0000_0004);
        fetch(1'b0, 1'b1);
        repeat (3) @(negedge CLOCK);
        chk(32'(TAG_HALT), 32'h0000_0000);
        @(posedge CLOCK);
        QUEUE_ADVANCE <= 1'b1;
        @(posedge CLOCK);
        QUEUE_ADVANCE <= 1'b0;
        repeat (2) @(negedge CLOCK);
        chk(32'(TAG_HALT), 32'h0000_0001);
        rdc(ba(`BKPT_IDX_IRQ_STATUS), 32'h0000_0004, 1'b0);
        @(posedge CLOCK);
        DEBUG_HALT <= 1'b1;
        repeat (3) @(negedge CLOCK);
        chk(32'({TAGGING, SERIAL_CMD_EN, TAG_HALT}), 32'h0000_0002);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CLOCK);
        RSTN <= 1'b1;
        t_regs;
        t_full;
        t_irq;
        t_dual;
        t_tag;
        results;
    end
    // Tests take about 250 cycles
    initial begin
        repeat (5000) @(posedge CLOCK);
        errors++;
        results;
    end
endmodule
